// File: bench/adc_readout_checker.sv
// Timing checks on the readout block's ports.
// Assumes a bench serial clock of eight clk periods.
`timescale 1ns/1ns
module adc_readout_checker(input wire clk, sys_rst, conversion_start_in,
	serial_clk_in, input wire [13:0] input_pair_zero, input_pair_one,
	input wire pair_zero_over, pair_zero_under, pair_one_over,
	pair_one_under, serial_data_out, serial_data_oe, reference_on,
	light_sleep, deep_sleep);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_ref_tracks_sleep: assert property (reference_on == !deep_sleep)
		else $error("reference level wrong");
	a_sleep_states_excl: assert property (!(light_sleep && deep_sleep))
		else $error("both sleep states");
	a_reset_idle_out: assert property ($fell(sys_rst) |->
		!serial_data_oe && reference_on && !light_sleep && !deep_sleep)
		else $error("not idle after reset");
	a_quiet_in_sleep: assert property ((light_sleep || deep_sleep)
		|-> !serial_data_oe) else $error("driving while asleep");
	a_deep_via_nap: assert property ($rose(deep_sleep) |->
		$past(light_sleep)) else $error("deep sleep not from nap");
	a_deep_exit_nap: assert property ($fell(deep_sleep) |-> light_sleep)
		else $error("deep sleep left not into nap");
	a_bit_holds: assert property ($rose(serial_data_oe) |=>
		$stable(serial_data_out)[*4]) else $error("bit not held");
	a_nap_wakes: assert property (light_sleep && $rose(serial_clk_in)
		|-> ##[1:8] !light_sleep) else $error("no wake from nap");
	c_nap: cover property ($rose(light_sleep));
	c_deep: cover property ($rose(deep_sleep));
	c_drive: cover property ($rose(serial_data_oe));
endmodule
bind adc_readout adc_readout_checker chk(.clk(clk), .sys_rst(sys_rst),
	.conversion_start_in(conversion_start_in),
	.serial_clk_in(serial_clk_in), .input_pair_zero(input_pair_zero),
	.input_pair_one(input_pair_one), .pair_zero_over(pair_zero_over),
	.pair_zero_under(pair_zero_under), .pair_one_over(pair_one_over),
	.pair_one_under(pair_one_under), .serial_data_out(serial_data_out),
	.serial_data_oe(serial_data_oe), .reference_on(reference_on),
	.light_sleep(light_sleep), .deep_sleep(deep_sleep));

// File: bench/adc_readout_tb.sv
// Self-checking bench of the readout block with a host model.
// Assumes the design and its constants header are compiled first.
`timescale 1ns/1ns
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin \
	n_mismatch++; $display("wrong value %s exp %h got %h", n, e, a); end end
module adc_readout_tb;
	logic clk, sys_rst, zo, zu, oo, ou; // Clock, reset, range flags.
	logic [13:0] z, o; // Raw codes of both input pairs.
	wire cs, sk, sd, oe, ref_on, nap, deep;
	wire [31:0] w; // Frame as captured by the host.
	int n_mismatch = 0, tests_run = 0;
	adc_readout dut(.clk(clk), .sys_rst(sys_rst),
		.conversion_start_in(cs), .serial_clk_in(sk),
		.input_pair_zero(z), .input_pair_one(o), .pair_zero_over(zo),
		.pair_zero_under(zu), .pair_one_over(oo), .pair_one_under(ou),
		.serial_data_out(sd), .serial_data_oe(oe), .reference_on(ref_on),
		.light_sleep(nap), .deep_sleep(deep));
	host_model h(.clk(clk), .serial_data_out(sd), .serial_data_oe(oe),
		.conversion_start_in(cs), .serial_clk_in(sk), .word_r(w));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Prints the verdict and ends the run.
	task stop_test();
		if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// One frame; codes and flags are set before the start edge.
	task t_frame(input logic [13:0] a, b, input logic [3:0] f,
		input logic [13:0] ea, eb);
		@(negedge clk);
		{z, o, zo, zu, oo, ou} = {a, b, f};
		h.start();
		h.sck(32);
		@(negedge clk); // Let the last falling-edge capture land.
		`CHK("word0", ea, w[29:16])
		`CHK("word1", eb, w[13:0])
		`CHK("gap", {~ea[0], ea[0]}, w[15:14])
	endtask
	// A start inside a frame changes nothing.
	task t_ignore();
		@(negedge clk);
		{z, o, zo, zu, oo, ou} = {14'h0F0F, 14'h3003, 4'h0};
		h.start();
		h.sck(10);
		{z, o} = {14'h1111, 14'h2222};
		h.start();
		h.sck(22);
		@(negedge clk); // Let the last falling-edge capture land.
		`CHK("held0", 14'h0F0F, w[29:16])
		`CHK("held1", 14'h3003, w[13:0])
	endtask
	// Two starts nap, a clock wakes, then a normal frame.
	task t_nap();
		h.start();
		h.start();
		`CHK("nap", 3'b110, {nap, ref_on, oe})
		h.sck(1);
		`CHK("awake", 1'b0, nap)
		h.sck(40);
		t_frame(14'h2A5C, 14'h15A3, 4'h0, 14'h2A5C, 14'h15A3);
	endtask
	// Four starts sleep deep; clock, nap, clock wake the block.
	task t_deep();
		repeat (4) h.start();
		`CHK("deep", 2'b10, {deep, ref_on})
		h.sck(1);
		h.start();
		h.start();
		`CHK("renap", 3'b011, {deep, nap, ref_on})
		h.sck(1);
		`CHK("woke", 1'b0, nap)
		h.sck(40);
		t_frame(14'h3C3C, 14'h0001, 4'h0, 14'h3C3C, 14'h0001);
	endtask
	// Watchdog against a hang: about four times the length of all tests.
	initial begin
		#200000;
		n_mismatch++;
		stop_test();
	end
	// Main sequence.
	initial begin
		sys_rst = 1'b1;
		{z, o, zo, zu, oo, ou} = 32'h0000_0000;
		repeat (6) @(posedge clk);
		@(negedge clk);
		sys_rst = 0;
		@(negedge clk);
		`CHK("idle", 4'b0100, {oe, ref_on, nap, deep})
		t_frame(14'h2A5C, 14'h15A3, 4'h0, 14'h2A5C, 14'h15A3);
		t_frame(14'h0001, 14'h3FFE, 4'h9, 14'h3FFF, 14'h0000);
		t_frame(14'h1234, 14'h0F0F, 4'h6, 14'h0000, 14'h3FFF);
		t_ignore();
		t_nap();
		t_deep();
		stop_test();
	end
endmodule

// File: bench/host_model.sv
// Host serial port model: drives start and serial clock, shifts data in.
// Assumes the bench clock clk; pins change only at its falling edge.
`timescale 1ns/1ns
module host_model(input wire clk, input wire serial_data_out,
	input wire serial_data_oe, output logic conversion_start_in,
	output logic serial_clk_in, output logic [31:0] word_r);
	logic line_r; // Level the host sees on the data line.
	initial begin
		conversion_start_in = 0;
		serial_clk_in = 0;
		word_r = 0;
		line_r = 0;
	end
	// Capture on falling serial clock; a released line reads inverted.
	always @(negedge serial_clk_in) begin
		line_r = serial_data_oe ? serial_data_out : ~line_r;
		word_r = {word_r[30:0], line_r};
	end
	// Serial clock of 160 ns; it stands still low between calls.
	task sck(input int n);
		repeat (n) begin
			repeat (4) @(negedge clk);
			serial_clk_in = 1;
			repeat (4) @(negedge clk);
			serial_clk_in = 0;
		end
	endtask
	// Start pulse one serial clock wide, then a quiet low time.
	task start();
		@(negedge clk);
		conversion_start_in = 1;
		repeat (8) @(negedge clk);
		conversion_start_in = 0;
		repeat (8) @(negedge clk);
	endtask
endmodule

// File: hdl/adc_readout.v
// Serial readout, framing and power-down control of a dual converter.
// Assumes start and serial clock pins are asynchronous to clk and that
// analog results arrive as saturation flags plus raw codes per channel.
`timescale 1ns/1ns
`include "adc_readout_consts.vh"

// ----------------------------------------------------------------
// Result FIFO
// ----------------------------------------------------------------
// Holds sampled result pairs until the serial shifter takes them.
module result_fifo #(
	parameter WIDTH = 28,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	clk,
	sys_rst,
	in_data,
	in_valid,
	in_ready,
	out_data,
	out_valid,
	out_ready
);
	input clk;
	input sys_rst;
	input [WIDTH-1:0] in_data;
	input in_valid;
	output in_ready;
	input out_ready;
	output [WIDTH-1:0] out_data;
	output out_valid;

	// Storage array and pointers with an extra wrap bit.
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0] wr_ptr_r;
	reg [AW:0] rd_ptr_r;
	wire full;
	wire empty;
	assign empty = (wr_ptr_r == rd_ptr_r);
	assign full = (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]) &&
		(wr_ptr_r[AW] != rd_ptr_r[AW]);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[rd_ptr_r[AW-1:0]];

	// Pointer update; a write and a read may happen together.
	always @(posedge clk) begin
		if (sys_rst) begin
			wr_ptr_r <= {(AW+1){1'b0}};
			rd_ptr_r <= {(AW+1){1'b0}};
		end else begin
			if (in_valid && !full) begin
				mem[wr_ptr_r[AW-1:0]] <= in_data;
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (out_ready && !empty) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
		end
	end
endmodule

// ----------------------------------------------------------------
// Readout top
// ----------------------------------------------------------------
// How it works
// (R1) Power-up lands in active state.
// (R2) Two starts without clock edge: light sleep.
// (R3) Reference stays on in light sleep.
// (R4) Serial clock edge wakes from light sleep.
// (R5) Four starts without clock edge: deep sleep.
// (R6) Host wakes deep sleep via clock, nap, clock.
// (R7) Deep to light sleep turns reference on.
// (R8) Host waits for reference to settle.
// (R9) Start begins frame; others ignored 32 clocks.
// (R10) Host picks start pulse duty cycle.
// (R11) Each clock edge steps conversion and data.
// (R12) Data begins third clock edge, MSB first.
// (R13) Host captures data on falling edges.
// (R14) Fourteen-bit results right-justified in 16 bits.
// (R15) Data pin released until conversion starts.
// (R16) Two released clocks between result words.
// (R17) Bit valid by next serial clock edge.
// (R18) Host drives device pins before its port.
// (R19) Results are natural binary codes.
// (R20) Out of range results saturate.
// (R21) Word one is pair zero, word two pair one.
module adc_readout (
	clk,
	sys_rst,
	conversion_start_in,
	serial_clk_in,
	input_pair_zero,
	input_pair_one,
	pair_zero_over,
	pair_zero_under,
	pair_one_over,
	pair_one_under,
	serial_data_out,
	serial_data_oe,
	reference_on,
	light_sleep,
	deep_sleep
);
	input clk;
	input sys_rst;
	input conversion_start_in;
	input serial_clk_in;
	input [`RES_W-1:0] input_pair_zero;
	input [`RES_W-1:0] input_pair_one;
	input pair_zero_over;
	input pair_zero_under;
	input pair_one_over;
	input pair_one_under;
	output serial_data_out;
	output serial_data_oe;
	output reference_on;
	output light_sleep;
	output deep_sleep;

	// Power states, one-hot.
	localparam ST_ACTIVE = 3'b001;
	localparam ST_NAP = 3'b010;
	localparam ST_SLEEP = 3'b100;

	// Two-stage synchronisers and edge history for the pins.
	reg [1:0] conversion_start_in_sync_r;
	reg [1:0] sck_sync_r;
	reg conversion_start_in_prev_r;
	reg sck_prev_r;
	wire conversion_start_in_rise;
	wire sck_rise;
	assign conversion_start_in_rise = conversion_start_in_sync_r[1] && !conversion_start_in_prev_r;
	assign sck_rise = sck_sync_r[1] && !sck_prev_r;
	// Falling serial clock edge: the host has taken the bit by then.
	wire sck_fall;
	assign sck_fall = !sck_sync_r[1] && sck_prev_r;

	// Frame and power state.
	reg [2:0] pwr_r;
	reg [2:0] pwr_nxt;
	reg [2:0] conversion_start_in_cnt_r;
	reg [5:0] frame_cnt_r;
	reg busy_r;
	reg [2*`RES_W-1:0] shift_r;
	reg sdo_r;
	reg sdo_oe_r;
	reg ref_on_r;
	reg nap_r;
	reg sleep_r;
	// Set from the last frame edge until the host has taken the last bit.
	reg tail_r;

	// Saturated codes for the sample taken at the start edge.
	wire [`RES_W-1:0] code0;
	wire [`RES_W-1:0] code1;
	assign code0 = pair_zero_over ? `CODE_FULL :
		(pair_zero_under ? `CODE_ZERO : input_pair_zero); // (R20) (R19)
	assign code1 = pair_one_over ? `CODE_FULL :
		(pair_one_under ? `CODE_ZERO : input_pair_one); // (R20) (R19)

	// FIFO between the sampler and the serial shifter.
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [2*`RES_W-1:0] fifo_out_data;
	wire start_ok;
	wire fifo_take;
	// A start is taken only while idle and awake enough to convert.
	assign start_ok = conversion_start_in_rise && !busy_r && pwr_r == ST_ACTIVE &&
		conversion_start_in_cnt_r == 3'h0 && fifo_in_ready;
	assign fifo_take = busy_r && sck_rise &&
		frame_cnt_r == `FIRST_BIT_CLK - 6'h01;

	result_fifo #(
		.WIDTH(2*`RES_W),
		.DEPTH(`FIFO_DEPTH),
		.AW(`FIFO_AW)
	) u_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_data({code0, code1}), // (R21)
		.in_valid(start_ok),
		.in_ready(fifo_in_ready),
		.out_data(fifo_out_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_take)
	);

	// Synchronise the pins before any logic reads them.
	always @(posedge clk) begin
		if (sys_rst) begin
			conversion_start_in_sync_r <= 2'b00;
			sck_sync_r <= 2'b00;
			conversion_start_in_prev_r <= 1'b0;
			sck_prev_r <= 1'b0;
		end else begin
			conversion_start_in_sync_r <= {conversion_start_in_sync_r[0], conversion_start_in};
			sck_sync_r <= {sck_sync_r[0], serial_clk_in};
			conversion_start_in_prev_r <= conversion_start_in_sync_r[1];
			sck_prev_r <= sck_sync_r[1];
		end
	end

	// Next power state from counted start edges and clock edges.
	always @* begin
		pwr_nxt = pwr_r;
		case (pwr_r)
			ST_ACTIVE: begin
				if (conversion_start_in_rise && conversion_start_in_cnt_r + 3'h1 == `NAP_EDGES)
					pwr_nxt = ST_NAP; // (R2)
			end
			ST_NAP: begin
				if (sck_rise)
					pwr_nxt = ST_ACTIVE; // (R4)
				else if (conversion_start_in_rise &&
					conversion_start_in_cnt_r + 3'h1 == `SLEEP_EDGES)
					pwr_nxt = ST_SLEEP; // (R5)
			end
			ST_SLEEP: begin
				// Clock edges re-arm counting; a nap request follows.
				if (conversion_start_in_rise && conversion_start_in_cnt_r + 3'h1 == `NAP_EDGES)
					pwr_nxt = ST_NAP; // (R6) (R7)
			end
			default: pwr_nxt = ST_ACTIVE;
		endcase
	end

	// Power state, edge counter and reference control.
	always @(posedge clk) begin
		if (sys_rst) begin
			pwr_r <= ST_ACTIVE; // (R1)
			conversion_start_in_cnt_r <= 3'h0;
			ref_on_r <= 1'b1;
			nap_r <= 1'b0;
			sleep_r <= 1'b0;
		end else begin
			pwr_r <= pwr_nxt;
			// Any rising serial clock edge clears the run of start edges.
			if (sck_rise)
				conversion_start_in_cnt_r <= 3'h0;
			// Every start edge of a run counts, also one that opens a
			// frame or that a running frame ignores; the count stops
			// at the deep sleep figure so that further starts hold it.
			else if (conversion_start_in_rise && conversion_start_in_cnt_r != `SLEEP_EDGES)
				conversion_start_in_cnt_r <= conversion_start_in_cnt_r + 3'h1; // (R2) (R5)
			// Reference off only in deep sleep; on again from nap.
			ref_on_r <= (pwr_nxt != ST_SLEEP); // (R3) (R7)
			nap_r <= (pwr_nxt == ST_NAP);
			sleep_r <= (pwr_nxt == ST_SLEEP);
		end
	end

	// Frame sequencer and serial shifter.
	always @(posedge clk) begin
		if (sys_rst) begin
			busy_r <= 1'b0;
			frame_cnt_r <= 6'h00;
			shift_r <= {2*`RES_W{1'b0}};
			sdo_r <= 1'b0;
			sdo_oe_r <= 1'b0; // (R15)
			tail_r <= 1'b0;
		end else if (start_ok) begin
			busy_r <= 1'b1; // (R9)
			frame_cnt_r <= 6'h00;
			// The first two clocks of a frame leave the line released.
			sdo_oe_r <= 1'b0; // (R15)
			tail_r <= 1'b0;
		end else if (tail_r && sck_fall) begin
			// The host has taken the last bit: release the line.
			sdo_oe_r <= 1'b0; // (R14) (R15)
			tail_r <= 1'b0;
		end else if (busy_r && sck_rise) begin
			// Every serial clock edge steps the frame one place.
			frame_cnt_r <= frame_cnt_r + 6'h01; // (R11)
			if (frame_cnt_r + 6'h01 == `FRAME_CLKS) begin
				// Last edge of the frame: its bit must stand until
				// the following falling edge, so the release waits.
				busy_r <= 1'b0; // (R9) (R14)
				tail_r <= 1'b1;
			end
			if (fifo_take) begin
				// Third edge: first MSB of pair zero goes out.
				sdo_r <= fifo_out_data[2*`RES_W-1]; // (R12) (R17)
				shift_r <= {fifo_out_data[2*`RES_W-2:0], 1'b0};
				sdo_oe_r <= 1'b1;
			end else if (frame_cnt_r + 6'h01 ==
				`FIRST_BIT_CLK + `WORD_CLKS) begin
				sdo_oe_r <= 1'b0; // (R16)
			end else if (frame_cnt_r + 6'h01 == `SECOND_BIT_CLK) begin
				sdo_r <= shift_r[2*`RES_W-1]; // (R12) (R21)
				shift_r <= {shift_r[2*`RES_W-2:0], 1'b0};
				sdo_oe_r <= 1'b1;
			end else if (frame_cnt_r + 6'h01 ==
				`SECOND_BIT_CLK + `WORD_CLKS) begin
				sdo_oe_r <= 1'b0; // (R14)
			end else if (sdo_oe_r) begin
				sdo_r <= shift_r[2*`RES_W-1]; // (R11) (R17)
				shift_r <= {shift_r[2*`RES_W-2:0], 1'b0};
			end
		end
	end

	assign serial_data_out = sdo_r;
	assign serial_data_oe = sdo_oe_r;
	assign reference_on = ref_on_r;
	assign light_sleep = nap_r;
	assign deep_sleep = sleep_r;
endmodule

// File: hdl/adc_readout_consts.vh
// Constants for the dual-channel converter serial readout block.
// Assumes inclusion by the design file only; definitions, no logic.
`ifndef ADC_READOUT_CONSTS_VH
`define ADC_READOUT_CONSTS_VH

// Width of one converted result.
`define RES_W 14
// Clocks in a full readout frame.
`define FRAME_CLKS 6'h20
// Frame clock at which the first data bit is driven.
`define FIRST_BIT_CLK 6'h03
// Frame clock at which the second word starts (after two idle clocks).
`define SECOND_BIT_CLK 6'h13
// Clocks of data in one word.
`define WORD_CLKS 6'h0E
// Start edges without a serial clock edge that request light sleep.
`define NAP_EDGES 3'h2
// Start edges without a serial clock edge that request deep sleep.
`define SLEEP_EDGES 3'h4
// Result codes at the two ends of the scale.
`define CODE_ZERO 14'h0000
`define CODE_FULL 14'h3FFF
// Depth of the result FIFO.
`define FIFO_DEPTH 8
// Address width of the result FIFO (log2 of its depth); pointers carry one more wrap bit.
`define FIFO_AW 3

`endif
